// *** pdtp_deadtime.v ***
// Dead-time unit: each edge of the raw PWM signal clears both outputs, then turns the new side on after the chosen dead time.
// Assumes the raw signal is synchronous to aclk; dead time counts aclk cycles.
`timescale 1ns/1ps

module pdtp_deadtime #(
    parameter DT_W = 12
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Settings
    input wire [DT_W-1:0] dt_rise,
    input wire [DT_W-1:0] dt_fall,
    // Signals
    input wire pwm_raw,
    output reg out_high,
    output reg out_low
);

    reg last_raw;
    reg [DT_W-1:0] count;

    // Primary delay guards the high side turn on, alternate the low side.
    always @(posedge aclk) begin
        if (!aresetn) begin
            last_raw <= 1'b0;
            count <= {DT_W{1'b0}};
            out_high <= 1'b0;
            out_low <= 1'b0;
        end else begin
            last_raw <= pwm_raw;
            if (pwm_raw != last_raw) begin
                out_high <= 1'b0;
                out_low <= 1'b0;
                count <= pwm_raw ? dt_rise : dt_fall;
            end else if (count != {DT_W{1'b0}}) begin
                count <= count - 1'b1;
            end else begin
                out_high <= pwm_raw;
                out_low <= ~pwm_raw;
            end
        end
    end

endmodule // pdtp_deadtime

// *** pdtp_defs.vh ***
// Register map, field positions and reset values of the PWM dead-time and trigger postscaler block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef PDTP_DEFS_VH
`define PDTP_DEFS_VH

// ======================================================================
// Register byte offsets
`define PDTP_OFF_DT_PRIMARY 8'h00
`define PDTP_OFF_DT_ALTERNATE 8'h04
`define PDTP_OFF_TRIG_CTRL 8'h08
`define PDTP_OFF_STATUS 8'h0C

// ======================================================================
// Field positions
`define PDTP_DT_MSB 13
`define PDTP_DT_LSB 2
`define PDTP_DIV_MSB 15
`define PDTP_DIV_LSB 13
`define PDTP_START_MSB 5
`define PDTP_START_LSB 0

// ======================================================================
// Reset values
`define PDTP_DT_RESET 12'h000
`define PDTP_DIV_RESET 3'h0
`define PDTP_START_RESET 6'h00

// ======================================================================
// AXI responses
`define PDTP_RESP_OKAY 2'h0
`define PDTP_RESP_SLVERR 2'h2

`endif

// *** pdtp_postscaler.v ***
// Trigger postscaler: arms on a roll counter match, then passes one trigger event in N+1.
// Assumes trigger events and the roll count are synchronous to aclk.
`timescale 1ns/1ps

module pdtp_postscaler #(
    parameter ROLL_W = 6,
    parameter DIV_W = 3
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire [DIV_W-1:0] divider,
    input wire [ROLL_W-1:0] start_match,
    input wire [ROLL_W-1:0] roll_count,
    input wire trig_event,
    // Result
    output reg armed,
    output reg trig_out,
    output reg [DIV_W-1:0] event_count
);

    wire next_armed;
    assign next_armed = armed | (roll_count == start_match);

    always @(posedge aclk) begin
        if (!aresetn) begin
            armed <= 1'b0;
            trig_out <= 1'b0;
            event_count <= {DIV_W{1'b0}};
        end else begin
            armed <= next_armed;
            trig_out <= 1'b0;
            // An event in the match cycle already counts.
            if (next_armed && trig_event) begin
                if (event_count >= divider) begin
                    event_count <= {DIV_W{1'b0}};
                    trig_out <= 1'b1;
                end else begin
                    event_count <= event_count + 1'b1;
                end
            end
        end
    end

endmodule // pdtp_postscaler

// *** pdtp_top.v ***
// Contract
// - Primary dead time, twelve bits at 13:2
// - Alternate dead time, twelve bits at 13:2
// - Dead-time bits 15:14, 1:0 read zero
// - Divider 15:13 fires once per N+1 events
// - Postscaler idle until roll count matches start
// - Implemented bits read/write except read-only status at 0x0C, reset to zero
//
// Per-generator dead-time and trigger postscaler registers behind an AXI4-Lite slave.
// Assumes one aclk domain and that the roll count and events are synchronous to it.
`timescale 1ns/1ps
`include "pdtp_defs.vh"

module pdtp_top #(
    parameter DT_W = 12,
    parameter ROLL_W = 6,
    parameter DIV_W = 3
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Generator side
    input wire [ROLL_W-1:0] roll_count,
    input wire trig_event,
    input wire pwm_raw,
    output reg [DT_W-1:0] dead_time_primary_value,
    output reg [DT_W-1:0] dead_time_alternate_value,
    output wire trig_out,
    output wire pwm_out_high,
    output wire pwm_out_low
);

    // ======================================================================
    // Registers
    reg [DT_W-1:0] dt_primary;
    reg [DT_W-1:0] dt_alternate;
    reg [DIV_W-1:0] trigger_divider;
    reg [ROLL_W-1:0] postscaler_start_match;
    wire ps_armed;
    wire [DIV_W-1:0] ps_count;

    // Write channel latches so address and data may arrive in either order.
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr[7:2] <= 6'h03);
        end
    endfunction

    // Zero padding makes unimplemented bits read as zero.
    function [15:0] dt_image;
        input [DT_W-1:0] dt;
        begin
            dt_image = {2'h0, dt, 2'h0};
        end
    endfunction

    wire [15:0] trig_image;
    assign trig_image = {trigger_divider, 7'h00, postscaler_start_match};

    wire do_write;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    wire [15:0] dt_p_merged;
    wire [15:0] dt_a_merged;
    wire [15:0] trig_merged;
    assign dt_p_merged = merge16(dt_image(dt_primary), w_data, w_strb);
    assign dt_a_merged = merge16(dt_image(dt_alternate), w_data, w_strb);
    assign trig_merged = merge16(trig_image, w_data, w_strb);

    // ======================================================================
    // Write path
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PDTP_RESP_OKAY;
            dt_primary <= `PDTP_DT_RESET;
            dt_alternate <= `PDTP_DT_RESET;
            trigger_divider <= `PDTP_DIV_RESET;
            postscaler_start_match <= `PDTP_START_RESET;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? `PDTP_RESP_OKAY : `PDTP_RESP_SLVERR;
                case (aw_addr[7:2])
                    `PDTP_OFF_DT_PRIMARY >> 2: begin
                        dt_primary <= dt_p_merged[`PDTP_DT_MSB:`PDTP_DT_LSB];
                    end
                    `PDTP_OFF_DT_ALTERNATE >> 2: begin
                        dt_alternate <= dt_a_merged[`PDTP_DT_MSB:`PDTP_DT_LSB];
                    end
                    `PDTP_OFF_TRIG_CTRL >> 2: begin
                        trigger_divider <= trig_merged[`PDTP_DIV_MSB:`PDTP_DIV_LSB];
                        postscaler_start_match <= trig_merged[`PDTP_START_MSB:`PDTP_START_LSB];
                    end
                    default: begin
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Read path
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h00000000;
        case (s_axi_araddr[7:2])
            `PDTP_OFF_DT_PRIMARY >> 2: next_rdata = {16'h0000, dt_image(dt_primary)};
            `PDTP_OFF_DT_ALTERNATE >> 2: next_rdata = {16'h0000, dt_image(dt_alternate)};
            `PDTP_OFF_TRIG_CTRL >> 2: next_rdata = {16'h0000, trig_image};
            `PDTP_OFF_STATUS >> 2: next_rdata = {27'h0000000, ps_count, ps_armed, 1'b0};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PDTP_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= mapped(s_axi_araddr) ? `PDTP_RESP_OKAY : `PDTP_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Generator side
    always @(posedge aclk) begin
        if (!aresetn) begin
            dead_time_primary_value <= `PDTP_DT_RESET;
            dead_time_alternate_value <= `PDTP_DT_RESET;
        end else begin
            dead_time_primary_value <= dt_primary;
            dead_time_alternate_value <= dt_alternate;
        end
    end

    pdtp_postscaler #(
        .ROLL_W(ROLL_W),
        .DIV_W(DIV_W)
    ) u_postscaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .divider(trigger_divider),
        .start_match(postscaler_start_match),
        .roll_count(roll_count),
        .trig_event(trig_event),
        .armed(ps_armed),
        .trig_out(trig_out),
        .event_count(ps_count)
    );

    pdtp_deadtime #(
        .DT_W(DT_W)
    ) u_deadtime (
        .aclk(aclk),
        .aresetn(aresetn),
        .dt_rise(dt_primary),
        .dt_fall(dt_alternate),
        .pwm_raw(pwm_raw),
        .out_high(pwm_out_high),
        .out_low(pwm_out_low)
    );

endmodule // pdtp_top

// *** pdtp_top_assertions.sv ***
// Concurrent checks on the ports of the dead-time and trigger postscaler block.
// Assumes it is bound to pdtp_top and sees only that module's ports.
`timescale 1ns/1ps

module pdtp_checker #(
    parameter DT_W = 12,
    parameter ROLL_W = 6,
    parameter DIV_W = 3
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Register bus
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_bvalid,
    // Generator side
    input wire trig_event,
    input wire trig_out,
    input wire pwm_raw,
    input wire pwm_out_high,
    input wire pwm_out_low,
    input wire [DT_W-1:0] dead_time_primary_value,
    input wire [DT_W-1:0] dead_time_alternate_value
);
    // ======================================================================
    // Properties
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // The address is still held in the cycle where the read data first appear.
    wire rd_first = s_axi_rvalid && s_axi_arready;

    property p_dt_pri;
        $changed(dead_time_primary_value) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
    endproperty
    a_dt_pri: assert property (p_dt_pri) else $error("primary value moved without write");
    property p_dt_alt;
        $changed(dead_time_alternate_value) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
    endproperty
    a_dt_alt: assert property (p_dt_alt) else $error("alternate value moved without write");
    property p_dt_rsv;
        rd_first && s_axi_araddr < 8'h08 |-> s_axi_rdata[31:14] == 18'h00000 && s_axi_rdata[1:0] == 2'h0;
    endproperty
    a_dt_rsv: assert property (p_dt_rsv) else $error("dead-time unused bits not zero");
    property p_tc_rsv;
        rd_first && s_axi_araddr == 8'h08 |-> s_axi_rdata[12:6] == 7'h00 && s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_tc_rsv: assert property (p_tc_rsv) else $error("trigger control unused bits not zero");
    property p_trig_cause;
        trig_out |-> $past(trig_event);
    endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger out without event");
    property p_rst_zero;
        disable iff (1'b0) (!aresetn ##1 !aresetn) |=> !trig_out && !pwm_out_high && !pwm_out_low
            && dead_time_primary_value == 12'h000 && dead_time_alternate_value == 12'h000;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("output not cleared by reset");
    property p_pwm_excl;
        !(pwm_out_high && pwm_out_low);
    endproperty
    a_pwm_excl: assert property (p_pwm_excl) else $error("both outputs high");
    property p_pwm_clear;
        $changed(pwm_raw) |-> ##[1:2] (!pwm_out_high && !pwm_out_low);
    endproperty
    a_pwm_clear: assert property (p_pwm_clear) else $error("outputs not cleared on edge");
endmodule // pdtp_checker

bind pdtp_top pdtp_checker #(.DT_W(DT_W), .ROLL_W(ROLL_W), .DIV_W(DIV_W)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
    .trig_event(trig_event), .trig_out(trig_out), .pwm_raw(pwm_raw), .pwm_out_high(pwm_out_high),
    .pwm_out_low(pwm_out_low), .dead_time_primary_value(dead_time_primary_value),
    .dead_time_alternate_value(dead_time_alternate_value));

// *** pdtp_top_tb.sv ***
// Self-checking testbench for the dead-time and trigger postscaler block.
// Assumes pdtp_top and its checker are compiled alongside.
`timescale 1ns/1ps
`include "pdtp_defs.vh"

module pdtp_top_tb;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h00000000;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg [5:0] roll = 6'h00;
    reg trig = 1'b0, raw = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, trig_o, out_h, out_l;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [11:0] dtp, dta;
    reg [31:0] got;
    reg [1:0] resp;
    integer n_errors = 0, checks_done = 0, n_trig = 0, i, k, n, base;

    pdtp_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .roll_count(roll), .trig_event(trig), .pwm_raw(raw),
        .dead_time_primary_value(dtp), .dead_time_alternate_value(dta), .trig_out(trig_o),
        .pwm_out_high(out_h), .pwm_out_low(out_l));

    // ======================================================================
    // Clock, monitor and tasks
    initial forever #10 aclk = ~aclk;
    always @(posedge aclk) if (trig_o === 1'b1) n_trig <= n_trig + 1;

    task chk(input [31:0] g, input [31:0] e);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("BAD %0t got %h expected %h", $time, g, e);
            end
        end
    endtask

    // Waits are unbounded here; the watchdog ends a hung handshake.
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (bvalid !== 1'b1);
            resp = bresp;
            bready <= 1'b0;
        end
    endtask

    task rd(input [7:0] a);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
            end while (rvalid !== 1'b1);
            got = rdata;
            resp = rresp;
            rready <= 1'b0;
        end
    endtask

    task do_reset;
        begin
            aresetn <= 1'b0;
            repeat (6) @(posedge aclk);
            aresetn <= 1'b1;
        end
    endtask

    task events(input integer cnt);
        integer j;
        begin
            for (j = 0; j < cnt; j = j + 1) begin
                @(posedge aclk);
                trig <= 1'b1;
                @(posedge aclk);
                trig <= 1'b0;
            end
            repeat (3) @(posedge aclk);
        end
    endtask

    task results;
        begin
            $display("errors %0d checks %0d", n_errors, checks_done);
            if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // ======================================================================
    // Tests
    initial begin
        do_reset;
        for (i = 0; i < 3; i = i + 1) begin
            rd({i[5:0], 2'b00});
            chk(got, 32'h00000000);
        end
        wr(`PDTP_OFF_DT_PRIMARY, 32'hFFFFFFFF);
        chk({30'h0, resp}, {30'h0, `PDTP_RESP_OKAY});
        rd(`PDTP_OFF_DT_PRIMARY);
        chk(got, 32'h00003FFC);
        chk({20'h00000, dtp}, 32'h00000FFF);
        wr(`PDTP_OFF_DT_ALTERNATE, 32'hFFFF5555);
        rd(`PDTP_OFF_DT_ALTERNATE);
        chk(got, 32'h00001554);
        chk({20'h00000, dta}, 32'h00000555);
        wr(`PDTP_OFF_TRIG_CTRL, 32'hFFFFFFFF);
        rd(`PDTP_OFF_TRIG_CTRL);
        chk(got, 32'h0000E03F);
        wr(8'h10, 32'hFFFFFFFF);
        chk({30'h0, resp}, {30'h0, `PDTP_RESP_SLVERR});
        rd(8'h10);
        chk(got, 32'h00000000);
        chk({30'h0, resp}, {30'h0, `PDTP_RESP_SLVERR});
        // Different primary and alternate values show which edge uses which.
        wr(`PDTP_OFF_DT_PRIMARY, 32'h0000000C);
        wr(`PDTP_OFF_DT_ALTERNATE, 32'h00000014);
        repeat (3) @(posedge aclk);
        raw <= 1'b1;
        n = 0;
        do begin @(posedge aclk); n = n + 1; end while (out_h !== 1'b1);
        // The output rises dt + 2 edges after the change and is first seen one edge later.
        chk(n, 3 + 3);
        chk({31'h0, out_l}, 32'h00000000);
        raw <= 1'b0;
        n = 0;
        do begin @(posedge aclk); n = n + 1; end while (out_l !== 1'b1);
        chk(n, 5 + 3);
        chk({31'h0, out_h}, 32'h00000000);
        for (k = 0; k < 8; k = k + 1) begin
            // A nonzero roll count keeps the reset start value of zero from arming early.
            roll <= 6'h01;
            do_reset;
            wr(`PDTP_OFF_TRIG_CTRL, {16'h0000, k[2:0], 7'h00, 6'h05});
            base = n_trig;
            events(2);
            chk(n_trig - base, 0);
            rd(`PDTP_OFF_STATUS);
            chk(got, 32'h00000000);
            roll <= 6'h05;
            @(posedge aclk);
            roll <= 6'h01;
            events(k + 1);
            chk(n_trig - base, 1);
            rd(`PDTP_OFF_STATUS);
            chk(got, 32'h00000002);
            events(k + 1);
            chk(n_trig - base, 2);
        end
        results;
    end

    initial begin
        #400000;
        n_errors = n_errors + 1;
        results;
    end
endmodule // pdtp_top_tb
